// *** include/rss_pkg.sv ***
/*
  Shared constants and types for the regulator start-up sequencer:
  clock rate, derived cycle counts, reference scaling, boot targets and
  the state encodings of the sequencer and of the gate dead-time timer.
  Assumes a single 125 MHz clock; all analog decisions arrive as
  comparator levels already synchronous to that clock.
*/
package rss_pkg;

  // Clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 8000;

  // Least times round up to whole cycles, never below one.
  function automatic int ceil_cycles(input int t_ps);
    int c;
    c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Switch-node blanking after the lower gate starts to fall.
  localparam int BLANK_TIME_NS       = 20;
  localparam int BLANK_CYCLES        = ceil_cycles(BLANK_TIME_NS * 1000);
  // Upper release delay after lower gate is low at zero current.
  localparam int ZERO_CUR_DELAY_NS   = 35;
  localparam int ZERO_CUR_CYCLES     = ceil_cycles(ZERO_CUR_DELAY_NS * 1000);
  localparam int DT_CNT_W            = 4;

  // Fixed delay before the output voltage may rise.
  localparam int RAMP_START_DELAY_US     = 100;
  localparam int RAMP_START_DELAY_CYCLES = ceil_cycles(RAMP_START_DELAY_US * 1000000);
  // Reference steps once per microsecond.
  localparam int RAMP_TICK_NS        = 1000;
  localparam int RAMP_TICK_CYCLES    = ceil_cycles(RAMP_TICK_NS * 1000);
  localparam int TICK_CNT_W          = 7;

  // Reference is held in quarter-millivolt units; 3.25 mV/us is 13 units.
  localparam int REF_W               = 14;
  localparam logic [REF_W-1:0] SLEW_STEP    = 14'h000D;
  localparam logic [REF_W-1:0] REF_RESET    = 14'h0000;
  // Boot targets picked by the captured data and clock levels.
  localparam logic [REF_W-1:0] BOOT_TARGET0 = 14'h1130;
  localparam logic [REF_W-1:0] BOOT_TARGET1 = 14'h0FA0;
  localparam logic [REF_W-1:0] BOOT_TARGET2 = 14'h0E10;
  localparam logic [REF_W-1:0] BOOT_TARGET3 = 14'h0C80;

  // Core phase count after reset and when no lane is strapped high.
  localparam logic [2:0] PHASES_DEFAULT = 3'h4;

  // Maps the captured two-bit boot code to a voltage target.
  function automatic logic [REF_W-1:0] boot_target(input logic [1:0] code);
    case (code)
      2'h0:    return BOOT_TARGET0;
      2'h1:    return BOOT_TARGET1;
      2'h2:    return BOOT_TARGET2;
      default: return BOOT_TARGET3;
    endcase
  endfunction

  typedef enum logic [2:0] {
    SEQ_SHUTDOWN    = 3'b000,
    SEQ_INIT        = 3'b001,
    SEQ_DETECT      = 3'b010,
    SEQ_START_DELAY = 3'b011,
    SEQ_RAMP        = 3'b100,
    SEQ_RUN         = 3'b101
  } rss_seq_state_type;

  typedef enum logic [2:0] {
    DT_OFF      = 3'b000,
    DT_LOW_ON   = 3'b001,
    DT_LOW_OFF  = 3'b010,
    DT_HIGH_ON  = 3'b011,
    DT_HIGH_OFF = 3'b100
  } rss_dt_state_type;

endpackage

// *** include/rss_gate_if.sv ***
/*
  Carrier between the sequencer and one dead-time timer: drive enable,
  modulator output and switch-node comparator levels in, gate drives out.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface rss_gate_if;
  logic drive_en;
  logic pwm;
  logic sw_cross;
  logic lower_low;
  logic upper_near_sw;
  logic sw_below_rev;
  logic upper_gate_drive;
  logic lower_gate_drive;

  modport seq (
    output drive_en, pwm, sw_cross, lower_low, upper_near_sw, sw_below_rev,
    input  upper_gate_drive, lower_gate_drive
  );
  modport drv (
    input  drive_en, pwm, sw_cross, lower_low, upper_near_sw, sw_below_rev,
    output upper_gate_drive, lower_gate_drive
  );
endinterface

// *** rtl/rss_deadtime.sv ***
/*
  Adaptive dead-time timer for one upper/lower gate pair.
  Assumes comparator levels are synchronous to mclk and that the
  modulator output is a clean level from the PWM logic.
*/
`timescale 1ns/10ps
module rss_deadtime
  import rss_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Gate channel.
  rss_gate_if.drv  gate
);

  rss_dt_state_type      state_reg;
  rss_dt_state_type      state_next;
  logic [DT_CNT_W-1:0]   blank_cnt_reg;
  logic [DT_CNT_W-1:0]   zero_cnt_reg;
  logic                  blank_done;
  logic                  zero_done;

  // Timer end conditions.
  assign blank_done = (blank_cnt_reg >= DT_CNT_W'(BLANK_CYCLES));
  assign zero_done  = (zero_cnt_reg >= DT_CNT_W'(ZERO_CUR_CYCLES));

  // Next gate state from modulator and comparators.
  always_comb
  begin
    state_next = state_reg;
    if (!gate.drive_en)
      state_next = DT_OFF;
    else
      case (state_reg)
        DT_OFF:      state_next = gate.pwm ? DT_LOW_OFF : DT_LOW_ON;
        DT_LOW_ON:   if (gate.pwm) state_next = DT_LOW_OFF;
        DT_LOW_OFF:
        begin
          if (!gate.pwm)
            state_next = DT_LOW_ON;
          else if (blank_done && gate.sw_cross)
            state_next = DT_HIGH_ON;
          else if (zero_done)
            state_next = DT_HIGH_ON;
        end
        DT_HIGH_ON:  if (!gate.pwm) state_next = DT_HIGH_OFF;
        DT_HIGH_OFF:
          if (gate.upper_near_sw || gate.sw_below_rev)
            state_next = DT_LOW_ON;
        default:     state_next = DT_OFF;
      endcase
  end

  // State register.
  always_ff @(posedge mclk)
    if (!rst_n)
      state_reg <= DT_OFF;
    else
      state_reg <= state_next;

  // Blanking and zero-current counters run only while the lower gate falls.
  always_ff @(posedge mclk)
    if (!rst_n || state_reg != DT_LOW_OFF)
    begin
      blank_cnt_reg <= '0;
      zero_cnt_reg  <= '0;
    end
    else
    begin
      if (!blank_done)
        blank_cnt_reg <= blank_cnt_reg + 1'b1;
      if (!gate.lower_low)
        zero_cnt_reg <= '0;
      else if (!zero_done)
        zero_cnt_reg <= zero_cnt_reg + 1'b1;
    end

  // Gate drives come straight from flip-flops.
  always_ff @(posedge mclk)
    if (!rst_n)
    begin
      gate.upper_gate_drive <= 1'b0;
      gate.lower_gate_drive <= 1'b0;
    end
    else
    begin
      gate.upper_gate_drive <= (state_next == DT_HIGH_ON);
      gate.lower_gate_drive <= (state_next == DT_LOW_ON);
    end

endmodule

// *** rtl/rss_sequencer.sv ***
/*
  Start-up sequencer for a dual-output buck controller: supply and
  enable gating, phase-count strapping, boot target capture, soft-start
  with pre-bias handling, power-good and adaptive gate dead time.
  Assumes every analog decision is a comparator level synchronous to mclk.
*/
`timescale 1ns/10ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned START_DELAY_CYCLES = RAMP_START_DELAY_CYCLES
)
(
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Supply power-on-reset flags.
  input  wire logic             main_por_ok,
  input  wire logic             driver_supply_por_ok,
  input  wire logic             lower_drive_supply_por_ok,
  // Enable comparator, rising and falling thresholds.
  input  wire logic             en_above_rise,
  input  wire logic             en_above_fall,
  // Phase strapping.
  input  wire logic             lane2_sense_neg,
  input  wire logic             lane3_sense_neg,
  input  wire logic             lane4_sense_neg,
  // Boot code levels.
  input  wire logic             vid_serial_data,
  input  wire logic             vid_serial_clock,
  // Output feedback comparators.
  input  wire logic             core_feedback_node_above_ref,
  input  wire logic             secondary_rail_feedback_node_above_ref,
  input  wire logic             core_in_window,
  input  wire logic             secondary_rail_in_window,
  // Core gate channel sensing.
  input  wire logic             core_pwm,
  input  wire logic             core_sw_cross,
  input  wire logic             core_lower_low,
  input  wire logic             core_upper_near_sw,
  input  wire logic             core_sw_below_rev,
  // Secondary gate channel sensing.
  input  wire logic             secondary_rail_pwm,
  input  wire logic             secondary_rail_sw_cross,
  input  wire logic             secondary_rail_lower_low,
  input  wire logic             secondary_rail_upper_near_sw,
  input  wire logic             secondary_rail_sw_below_rev,
  // Gate drives.
  output logic                  core_upper_gate_drive,
  output logic                  core_lower_gate_drive,
  output logic                  secondary_rail_upper_gate_drive,
  output logic                  secondary_rail_lower_gate_drive,
  // References and configuration.
  output logic [REF_W-1:0]      core_target,
  output logic [REF_W-1:0]      secondary_rail_target,
  output logic [REF_W-1:0]      core_reference,
  output logic [REF_W-1:0]      secondary_rail_reference,
  output logic [2:0]            core_phase_count,
  output logic                  soft_start_active,
  // Open-drain power-good.
  output logic                  output_ok_flag_out,
  output logic                  output_ok_flag_oe_n
);

  rss_seq_state_type            state_reg;
  rss_seq_state_type            state_next;
  logic                         enable_reg;
  logic                         targets_valid_reg;
  logic [1:0]                   boot_code_reg;
  logic [31:0]                  delay_cnt_reg;
  logic [TICK_CNT_W-1:0]        tick_cnt_reg;
  logic                         tick;
  logic                         all_supplies_ok;
  logic                         drop;
  logic                         ramp_done;
  logic                         core_en_reg;
  logic                         sec_en_reg;
  logic                         pgood_release_reg;

  rss_gate_if core_gate ();
  rss_gate_if sec_gate ();

  // Steps a reference toward its target without passing it.
  function automatic logic [REF_W-1:0] step_toward(
    input logic [REF_W-1:0] cur,
    input logic [REF_W-1:0] tgt
  );
    logic [REF_W:0] sum;
    sum = {1'b0, cur} + {1'b0, SLEW_STEP};
    if (sum >= {1'b0, tgt})
      return tgt;
    return sum[REF_W-1:0];
  endfunction

  // Enable comparator; clears only below the lower threshold.
  // Hysteresis on enable.
  always_ff @(posedge mclk)
    if (!rst_n)
      enable_reg <= 1'b0;
    else if (en_above_rise)
      enable_reg <= 1'b1;
    else if (!en_above_fall)
      enable_reg <= 1'b0;

  // Supply and enable summary terms.
  // All supply flags needed.
  assign all_supplies_ok = main_por_ok && driver_supply_por_ok && lower_drive_supply_por_ok;
  assign drop = !all_supplies_ok || !enable_reg;

  // Sequencer next state.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SEQ_SHUTDOWN:
        if (main_por_ok)
          state_next = SEQ_INIT;
      SEQ_INIT:
        if (!main_por_ok)
          state_next = SEQ_SHUTDOWN;
        else if (all_supplies_ok && enable_reg && targets_valid_reg)
          state_next = SEQ_DETECT;
      SEQ_DETECT:
        state_next = drop ? SEQ_SHUTDOWN : SEQ_START_DELAY;
      SEQ_START_DELAY:
        if (drop)
          state_next = SEQ_SHUTDOWN;
        else if (delay_cnt_reg == START_DELAY_CYCLES - 1)
          state_next = SEQ_RAMP;
      SEQ_RAMP:
        if (drop)
          state_next = SEQ_SHUTDOWN;
        else if (ramp_done)
          state_next = SEQ_RUN;
      SEQ_RUN:
        if (drop)
          state_next = SEQ_SHUTDOWN;
      default:
        state_next = SEQ_SHUTDOWN;
    endcase
  end

  // State register.
  always_ff @(posedge mclk)
    if (!rst_n)
      state_reg <= SEQ_SHUTDOWN;
    else
      state_reg <= state_next;

  // Boot code capture, held until enable falls or main supply resets.
  always_ff @(posedge mclk)
    if (!rst_n)
    begin
      targets_valid_reg <= 1'b0;
      boot_code_reg     <= 2'h0;
    end
    else if (!enable_reg || !main_por_ok)
      targets_valid_reg <= 1'b0;
    else if (state_reg == SEQ_INIT && !targets_valid_reg)
    begin
      targets_valid_reg <= 1'b1;
      boot_code_reg     <= {vid_serial_data, vid_serial_clock};
    end

  // Phase-count strapping, sampled once before soft-start.
  always_ff @(posedge mclk)
    if (!rst_n)
      core_phase_count <= PHASES_DEFAULT;
    else if (state_reg == SEQ_DETECT)
    begin
      if (lane4_sense_neg && lane3_sense_neg && lane2_sense_neg)
        core_phase_count <= 3'h1;
      else if (lane4_sense_neg && lane3_sense_neg)
        core_phase_count <= 3'h2;
      else if (lane4_sense_neg)
        core_phase_count <= 3'h3;
      else
        core_phase_count <= PHASES_DEFAULT;
    end

  // Start delay counter.
  always_ff @(posedge mclk)
    if (!rst_n || state_reg != SEQ_START_DELAY)
      delay_cnt_reg <= 32'h0000_0000;
    else
      delay_cnt_reg <= delay_cnt_reg + 32'h0000_0001;

  // One-microsecond slew tick while ramping.
  always_ff @(posedge mclk)
    if (!rst_n || state_reg != SEQ_RAMP)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;

  assign tick = (tick_cnt_reg == TICK_CNT_W'(RAMP_TICK_CYCLES - 1));

  // Target load at the start of soft-start.
  always_ff @(posedge mclk)
    if (!rst_n || state_reg == SEQ_SHUTDOWN)
    begin
      core_target           <= REF_RESET;
      secondary_rail_target <= REF_RESET;
    end
    else if (state_reg == SEQ_DETECT && state_next == SEQ_START_DELAY)
    begin
      core_target           <= boot_target(boot_code_reg);
      secondary_rail_target <= boot_target(boot_code_reg);
    end

  // Ramping references for both outputs.
  always_ff @(posedge mclk)
    if (!rst_n || state_reg == SEQ_SHUTDOWN || state_reg == SEQ_INIT)
    begin
      core_reference           <= REF_RESET;
      secondary_rail_reference <= REF_RESET;
    end
    else if (state_reg == SEQ_RAMP && tick)
    begin
      core_reference           <= step_toward(core_reference, core_target);
      secondary_rail_reference <= step_toward(secondary_rail_reference, secondary_rail_target);
    end

  // Ramp ends when both references reach their targets.
  assign ramp_done = (core_reference == core_target) && (secondary_rail_reference == secondary_rail_target);
  assign soft_start_active = (state_reg == SEQ_START_DELAY) || (state_reg == SEQ_RAMP);

  // Drive enables with pre-bias handling; once on they stay on until the sequencer leaves ramp or run.
  always_ff @(posedge mclk)
    if (!rst_n || (state_reg != SEQ_RAMP && state_reg != SEQ_RUN))
    begin
      core_en_reg <= 1'b0;
      sec_en_reg  <= 1'b0;
    end
    else if (state_reg == SEQ_RUN)
    begin
      core_en_reg <= 1'b1;
      sec_en_reg  <= 1'b1;
    end
    else
    begin
      if (!core_feedback_node_above_ref)
        core_en_reg <= 1'b1;
      if (!secondary_rail_feedback_node_above_ref)
        sec_en_reg <= 1'b1;
    end

  // Power-good release; pin is pulled low otherwise.
  always_ff @(posedge mclk)
    if (!rst_n)
      pgood_release_reg <= 1'b0;
    else
      pgood_release_reg <= (state_reg == SEQ_RUN) && core_in_window && secondary_rail_in_window;

  assign output_ok_flag_out  = 1'b0;
  assign output_ok_flag_oe_n = pgood_release_reg;

  // Core gate channel hookup.
  assign core_gate.drive_en      = core_en_reg;
  assign core_gate.pwm           = core_pwm;
  assign core_gate.sw_cross      = core_sw_cross;
  assign core_gate.lower_low     = core_lower_low;
  assign core_gate.upper_near_sw = core_upper_near_sw;
  assign core_gate.sw_below_rev  = core_sw_below_rev;
  assign core_upper_gate_drive   = core_gate.upper_gate_drive;
  assign core_lower_gate_drive   = core_gate.lower_gate_drive;

  // Secondary gate channel hookup.
  assign sec_gate.drive_en                = sec_en_reg;
  assign sec_gate.pwm                     = secondary_rail_pwm;
  assign sec_gate.sw_cross                = secondary_rail_sw_cross;
  assign sec_gate.lower_low               = secondary_rail_lower_low;
  assign sec_gate.upper_near_sw           = secondary_rail_upper_near_sw;
  assign sec_gate.sw_below_rev            = secondary_rail_sw_below_rev;
  assign secondary_rail_upper_gate_drive  = sec_gate.upper_gate_drive;
  assign secondary_rail_lower_gate_drive  = sec_gate.lower_gate_drive;

  // Dead-time timers.
  rss_deadtime u_core_dt
  (
    .mclk (mclk),
    .rst_n(rst_n),
    .gate (core_gate)
  );

  rss_deadtime u_sec_dt
  (
    .mclk (mclk),
    .rst_n(rst_n),
    .gate (sec_gate)
  );

endmodule

// *** testbench/rss_sequencer_monitor.sv ***
/*
  Concurrent checks on the start-up sequencer, bound to its top module.
  Assumes the single clock mclk and the synchronous active-low rst_n.
*/
`timescale 1ns/10ps
module rss_sequencer_monitor
  import rss_pkg::*;
#(
  parameter int unsigned START_DELAY_CYCLES = RAMP_START_DELAY_CYCLES
)
(
  // Clock and reset.
  input wire logic             mclk,
  input wire logic             rst_n,
  // Supplies and enable.
  input wire logic             main_por_ok,
  input wire logic             driver_supply_por_ok,
  input wire logic             lower_drive_supply_por_ok,
  input wire logic             en_above_fall,
  // Straps and windows.
  input wire logic             lane2_sense_neg,
  input wire logic             lane3_sense_neg,
  input wire logic             lane4_sense_neg,
  input wire logic             core_in_window,
  input wire logic             secondary_rail_in_window,
  // Watched outputs.
  input wire logic             core_upper_gate_drive,
  input wire logic             core_lower_gate_drive,
  input wire logic             secondary_rail_upper_gate_drive,
  input wire logic             secondary_rail_lower_gate_drive,
  input wire logic [REF_W-1:0] core_target,
  input wire logic [REF_W-1:0] core_reference,
  input wire logic [2:0]       core_phase_count,
  input wire logic             soft_start_active,
  input wire logic             output_ok_flag_oe_n
);
  logic [15:0] ss_cnt_reg;
  logic [2:0]  exp_ph;
  logic        gates_off;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Counts cycles since soft-start began.
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !soft_start_active)
      ss_cnt_reg <= 16'h0000;
    else
      ss_cnt_reg <= ss_cnt_reg + 16'h0001;
  end

  // Phase count expected from the straps.
  always_comb
  begin
    case ({lane4_sense_neg, lane3_sense_neg, lane2_sense_neg})
      3'h4:    exp_ph = 3'h3;
      3'h6:    exp_ph = 3'h2;
      3'h7:    exp_ph = 3'h1;
      default: exp_ph = PHASES_DEFAULT;
    endcase
  end
  assign gates_off = !core_upper_gate_drive && !core_lower_gate_drive &&
                     !secondary_rail_upper_gate_drive && !secondary_rail_lower_gate_drive;

  AST_NO_SHOOT_CORE: assert property (!(core_upper_gate_drive && core_lower_gate_drive))
    else $error("core gates both on");
  AST_NO_SHOOT_SEC: assert property (!(secondary_rail_upper_gate_drive && secondary_rail_lower_gate_drive))
    else $error("secondary gates both on");
  AST_BLANK: assert property ($fell(core_lower_gate_drive) |-> !core_upper_gate_drive [*3])
    else $error("upper gate on inside blanking");
  AST_POR_OFF: assert property (!(main_por_ok && driver_supply_por_ok && lower_drive_supply_por_ok) [*4]
    |-> gates_off && !soft_start_active) else $error("running without supplies");
  AST_EN_SHUT: assert property (!en_above_fall [*4] |-> !soft_start_active && !output_ok_flag_oe_n)
    else $error("running while disabled");
  AST_PHASE: assert property ($rose(soft_start_active) |-> core_phase_count == exp_ph)
    else $error("phase count wrong");
  AST_REF_HOLD: assert property (soft_start_active && $past(soft_start_active) &&
    ss_cnt_reg < START_DELAY_CYCLES |-> $stable(core_reference)) else $error("reference moved early");
  AST_DRV_HOLD: assert property (soft_start_active && ss_cnt_reg < START_DELAY_CYCLES |-> gates_off)
    else $error("gates on during start delay");
  AST_SLEW: assert property (soft_start_active && $past(soft_start_active) && $changed(core_reference)
    |-> core_reference == $past(core_reference) + SLEW_STEP || core_reference == core_target)
    else $error("reference step wrong");
  AST_PG_SS: assert property (soft_start_active |-> !output_ok_flag_oe_n)
    else $error("power good during soft-start");
  AST_PG_WIN: assert property (output_ok_flag_oe_n |-> $past(core_in_window && secondary_rail_in_window))
    else $error("power good outside window");

  // Main scenarios reached.
  COV_RAMP_END: cover property ($fell(soft_start_active) && core_reference == core_target);
  COV_PG: cover property ($rose(output_ok_flag_oe_n));
  COV_UPPER: cover property ($rose(core_upper_gate_drive));
endmodule

bind rss_sequencer rss_sequencer_monitor #(.START_DELAY_CYCLES(START_DELAY_CYCLES)) i_rss_sequencer_monitor (.*);

// *** testbench/rss_power_stage_model.sv ***
/*
  Behavioural power stage for one channel: turns gate drives into
  switch-node and gate comparator levels. Assumes gates change on mclk.
*/
`timescale 1ns/10ps
module rss_power_stage_model
(
  // Clock and fault mode.
  input wire logic  mclk,
  input wire logic  zero_cur,
  // Gate drives from the device.
  input wire logic  upper_gate_drive,
  input wire logic  lower_gate_drive,
  // Comparator levels back to the device.
  output wire logic sw_cross,
  output wire logic lower_low,
  output wire logic upper_near_sw,
  output wire logic sw_below_rev
);
  logic lo_d = 1'b0;
  logic up_d = 1'b0;

  // Gates take one cycle to discharge.
  always @(posedge mclk)
  begin
    lo_d <= lower_gate_drive;
    up_d <= upper_gate_drive;
  end

  // With zero current the node never crosses.
  assign lower_low = !lo_d && !lower_gate_drive;
  assign sw_cross = lower_low && !zero_cur;
  assign upper_near_sw = !up_d && !upper_gate_drive;
  assign sw_below_rev = upper_near_sw;
endmodule

// *** testbench/rss_sequencer_tb_top.sv ***
/*
  Self-checking bench for the start-up sequencer with two power stages.
  Assumes a 125 MHz mclk and a shortened start delay.
*/
`timescale 1ns/10ps
module rss_sequencer_tb_top
  import rss_pkg::*;
;
  localparam int SD = 20;
  typedef struct {logic [1:0] c; logic [2:0] l; logic [2:0] p; logic [REF_W-1:0] t;} rss_row_type;
  rss_row_type rows [4] = '{'{2'h0, 3'h0, 3'h4, BOOT_TARGET0}, '{2'h1, 3'h4, 3'h3, BOOT_TARGET1},
                            '{2'h2, 3'h6, 3'h2, BOOT_TARGET2}, '{2'h3, 3'h7, 3'h1, BOOT_TARGET3}};
  logic mclk = 1'b0, rst_n = 1'b0, zc = 1'b0;
  logic main_por_ok = 1'b0, driver_supply_por_ok = 1'b0, lower_drive_supply_por_ok = 1'b0;
  logic en_above_rise = 1'b0, en_above_fall = 1'b0, vid_serial_data = 1'b0, vid_serial_clock = 1'b0;
  logic lane2_sense_neg = 1'b0, lane3_sense_neg = 1'b0, lane4_sense_neg = 1'b0;
  logic core_feedback_node_above_ref = 1'b0, secondary_rail_feedback_node_above_ref = 1'b0;
  logic core_in_window = 1'b0, secondary_rail_in_window = 1'b0;
  logic [7:0] pc = 8'h00;
  wire  core_pwm = pc[4];
  wire  secondary_rail_pwm = pc[4];
  wire  core_sw_cross, core_lower_low, core_upper_near_sw, core_sw_below_rev;
  wire  secondary_rail_sw_cross, secondary_rail_lower_low;
  wire  secondary_rail_upper_near_sw, secondary_rail_sw_below_rev;
  logic core_upper_gate_drive, core_lower_gate_drive;
  logic secondary_rail_upper_gate_drive, secondary_rail_lower_gate_drive;
  logic [REF_W-1:0] core_target, secondary_rail_target, core_reference, secondary_rail_reference;
  logic [2:0] core_phase_count;
  logic soft_start_active, output_ok_flag_out, output_ok_flag_oe_n;
  int n_fail = 0, tests_run = 0, r;

  rss_sequencer #(.START_DELAY_CYCLES(SD)) i_rss_sequencer (.*);
  rss_power_stage_model i_rss_power_stage_model (.mclk(mclk), .zero_cur(zc),
    .upper_gate_drive(core_upper_gate_drive), .lower_gate_drive(core_lower_gate_drive),
    .sw_cross(core_sw_cross), .lower_low(core_lower_low), .upper_near_sw(core_upper_near_sw),
    .sw_below_rev(core_sw_below_rev));
  rss_power_stage_model i_rss_power_stage_model_2 (.mclk(mclk), .zero_cur(1'b0),
    .upper_gate_drive(secondary_rail_upper_gate_drive), .lower_gate_drive(secondary_rail_lower_gate_drive),
    .sw_cross(secondary_rail_sw_cross), .lower_low(secondary_rail_lower_low),
    .upper_near_sw(secondary_rail_upper_near_sw), .sw_below_rev(secondary_rail_sw_below_rev));

  // Clock and a free-running modulator of 32 cycles.
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
    pc <= pc + 8'h01;

  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function logic pick(input int w);
    case (w)
      0: return soft_start_active;
      1: return core_upper_gate_drive;
      2: return secondary_rail_upper_gate_drive;
      default: return core_reference != '0;
    endcase
  endfunction

  // Waits a bounded time for a level, then compares it.
  task wait_for(input int w, input logic v);
    int i;
    for (i = 0; i < 40000 && pick(w) !== v; i++)
      tick(1);
    chk({15'h0000, pick(w)}, {15'h0000, v});
  endtask

  task test_done;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog against a hang.
  initial
  begin
    #(8 * 45000);
    n_fail++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    tick(20);
    rst_n = 1'b1;
    chk(core_phase_count, PHASES_DEFAULT);
    chk({output_ok_flag_out, output_ok_flag_oe_n, core_upper_gate_drive, core_lower_gate_drive}, 0);
    lower_drive_supply_por_ok = 1'b1;
    driver_supply_por_ok = 1'b1;
    en_above_rise = 1'b1;
    en_above_fall = 1'b1;
    tick(40);
    chk(soft_start_active, 0);
    main_por_ok = 1'b1;
    driver_supply_por_ok = 1'b0;
    tick(40);
    chk(soft_start_active, 0);
    en_above_rise = 1'b0;
    en_above_fall = 1'b0;
    driver_supply_por_ok = 1'b1;
    tick(4);
    for (r = 0; r < 4; r++)
    begin
      {vid_serial_data, vid_serial_clock} = rows[r].c;
      {lane4_sense_neg, lane3_sense_neg, lane2_sense_neg} = rows[r].l;
      // Drivers are up before enable rises.
      en_above_rise = 1'b1;
      en_above_fall = 1'b1;
      wait_for(0, 1);
      tick(1);
      chk(core_target, rows[r].t);
      chk(secondary_rail_target, rows[r].t);
      chk(core_phase_count, rows[r].p);
      {vid_serial_data, vid_serial_clock} = ~rows[r].c;
      en_above_rise = 1'b0;
      tick(4);
      chk(core_target, rows[r].t);
      chk(soft_start_active, 1);
      en_above_fall = 1'b0;
      wait_for(0, 0);
    end
    {vid_serial_data, vid_serial_clock} = 2'h3;
    {lane4_sense_neg, lane3_sense_neg, lane2_sense_neg} = 3'h0;
    core_feedback_node_above_ref = 1'b1;
    secondary_rail_feedback_node_above_ref = 1'b1;
    en_above_rise = 1'b1;
    en_above_fall = 1'b1;
    wait_for(0, 1);
    wait_for(3, 1);
    chk(core_reference, SLEW_STEP);
    tick(125);
    chk(core_reference, SLEW_STEP + SLEW_STEP);
    chk({core_upper_gate_drive, core_lower_gate_drive}, 0);
    core_feedback_node_above_ref = 1'b0;
    wait_for(1, 1);
    chk({secondary_rail_upper_gate_drive, secondary_rail_lower_gate_drive}, 0);
    wait_for(0, 0);
    chk(core_reference, BOOT_TARGET3);
    chk(secondary_rail_reference, BOOT_TARGET3);
    wait_for(2, 1);
    core_in_window = 1'b1;
    secondary_rail_in_window = 1'b1;
    tick(3);
    chk(output_ok_flag_oe_n, 1);
    secondary_rail_in_window = 1'b0;
    tick(3);
    chk(output_ok_flag_oe_n, 0);
    zc = 1'b1;
    wait_for(1, 0);
    wait_for(1, 1);
    lower_drive_supply_por_ok = 1'b0;
    tick(4);
    chk({output_ok_flag_oe_n, core_upper_gate_drive, core_lower_gate_drive, soft_start_active}, 0);
    // A reset during soft-start clears the loaded target and returns to shutdown.
    lower_drive_supply_por_ok = 1'b1;
    wait_for(0, 1);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    chk(core_target, REF_RESET);
    chk(soft_start_active, 0);
    test_done();
  end
endmodule
